// ==== core/ier_pkg.sv ====
`default_nettype none
package ier_pkg;
	// byte offsets on the register bus
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_ADDR_LOW = 8'h04;
	localparam logic [7:0] OFS_ADDR_HIGH = 8'h08;
	localparam logic [7:0] OFS_SOURCE_IDS = 8'h0c;
	localparam logic [7:0] OFS_ERR_CTRL = 8'h10;
	localparam logic [7:0] OFS_IRQ_STATUS = 8'h14;
	localparam logic [7:0] OFS_IRQ_MASK = 8'h18;
	// status, source id and control word fields
	localparam int BIT_AV = 31;
	localparam int BIT_V = 30;
	localparam int BIT_UE = 29;
	localparam int BIT_OF = 27;
	localparam int BIT_MV = 26;
	localparam int CLASS_LSB = 0;
	localparam int CLASS_W = 8;
	localparam int TXN_LSB = 8;
	localparam int TXN_W = 24;
	localparam int NODE_LSB = 0;
	localparam int NODE_W = 8;
	localparam int BIT_UI = 2;
	// error class codes
	localparam logic [7:0] CLASS_NONE = 8'h00;
	localparam logic [7:0] CLASS_DECODE = 8'h13;
	localparam logic [7:0] CLASS_SLAVE_RESP = 8'h18;
	localparam logic [7:0] CLASS_TIMEOUT = 8'h20;
	// interrupt status and mask layout
	localparam int IRQ_LOGGED = 0;
	localparam int IRQ_OVERFLOW = 1;
	localparam int IRQ_UNCORR = 2;
	localparam int IRQ_W = 3;
	localparam logic [IRQ_W-1:0] RST_IRQ = 3'h0;
	localparam logic [31:0] READ_UNMAPPED = 32'h0;

	typedef enum logic [0:0] {
		ier_ph_idle = 1'b0,
		ier_ph_answer = 1'b1
	} ier_phase_t;

	typedef struct packed {
		logic v;
		logic av;
		logic ue;
		logic of;
		logic mv;
		logic ui;
		logic [7:0] serr;
		logic [63:0] addr;
		logic [23:0] txn;
		logic [7:0] node;
		logic [31:0] rdata;
	} ier_state_t;

	localparam ier_state_t RST_STATE = '0;

	function automatic logic ier_hit(input logic [7:0] a, input logic [7:0] ofs);
		return a == ofs;
	endfunction
endpackage
`default_nettype wire

// ==== core/ier_bus_slave.sv ====
`timescale 1ns/1ps
`default_nettype none
// one wait state for every access: readdata is loaded in the first cycle
// and stands in the second, where waitrequest drops and the access commits
module ier_bus_slave (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// request
	input wire logic avs_read,
	input wire logic avs_write,
	// handshake
	output logic avs_waitrequest,
	output logic load,
	output logic commit
);
	typedef struct packed {
		ier_pkg::ier_phase_t phase;
	} ier_slave_state_t;

	ier_slave_state_t s;
	ier_slave_state_t next_s;
	logic req;

	always_comb begin
		req = avs_read | avs_write;
		next_s = s;
		load = req & (s.phase == ier_pkg::ier_ph_idle);
		commit = req & (s.phase == ier_pkg::ier_ph_answer);
		avs_waitrequest = req & (s.phase != ier_pkg::ier_ph_answer);
		unique case (s.phase)
			ier_pkg::ier_ph_idle: begin
				if (req) begin
					next_s.phase = ier_pkg::ier_ph_answer;
				end
			end
			ier_pkg::ier_ph_answer: begin
				next_s.phase = ier_pkg::ier_ph_idle;
			end
		endcase
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s.phase <= ier_pkg::ier_ph_idle;
		end else begin
			s <= next_s;
		end
	end

	sequence s_wait_cycle;
		req && avs_waitrequest;
	endsequence

	sequence s_done_cycle;
		req && !avs_waitrequest && commit;
	endsequence

	property p_one_wait;
		@(posedge ref_clk) disable iff (!nrst)
		s_wait_cycle |=> s_done_cycle;
	endproperty

	a_bus_one_wait: assert property (p_one_wait)
		else $error("request not answered after one wait state");
endmodule
`default_nettype wire

// ==== core/ier_irq.sv ====
`timescale 1ns/1ps
`default_nettype none
module ier_irq (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// events and software access
	input wire logic [2:0] event_in,
	input wire logic [2:0] ack_bits,
	input wire logic mask_we,
	input wire logic [2:0] mask_in,
	// state
	output logic [2:0] status,
	output logic [2:0] mask,
	output logic irq
);
	typedef struct packed {
		logic [2:0] status;
		logic [2:0] mask;
	} ier_irq_state_t;

	ier_irq_state_t s;
	ier_irq_state_t next_s;

	always_comb begin
		next_s = s;
		// a new event in the read-clear cycle survives
		next_s.status = (s.status & ~ack_bits) | event_in;
		if (mask_we) begin
			next_s.mask = mask_in;
		end
		status = s.status;
		mask = s.mask;
		irq = |(s.status & s.mask);
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s.status <= ier_pkg::RST_IRQ;
			s.mask <= ier_pkg::RST_IRQ;
		end else begin
			s <= next_s;
		end
	end

	a_irq_set_wins: assert property (@(posedge ref_clk) disable iff (!nrst)
		(event_in[0] && ack_bits[0]) |=> status[0])
		else $error("event lost in read-clear cycle");

	a_irq_read_clear: assert property (@(posedge ref_clk) disable iff (!nrst)
		(ack_bits[1] && !event_in[1]) |=> !status[1])
		else $error("overflow interrupt bit not cleared by read");
endmodule
`default_nettype wire

// ==== core/ier_main.sv ====
// The register offsets and the Avalon-MM register port were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module ier_main (
	// clock and reset
	input wire logic ref_clk,
	input wire logic nrst,
	// register bus
	input wire logic [7:0] avs_address,
	input wire logic avs_read,
	input wire logic avs_write,
	input wire logic [31:0] avs_writedata,
	input wire logic [3:0] avs_byteenable,
	input wire logic avs_secure,
	output logic [31:0] avs_readdata,
	output logic avs_waitrequest,
	// detected faults from the slave-side interface
	input wire logic err_valid,
	input wire logic [7:0] err_class,
	input wire logic err_uncorrected,
	input wire logic [63:0] err_addr,
	input wire logic [23:0] err_txn_id,
	input wire logic [7:0] err_node_id,
	// interrupt
	output logic irq
);
	ier_pkg::ier_state_t s;
	ier_pkg::ier_state_t next_s;

	logic load;
	logic commit;
	logic wr;
	logic st_wr;
	logic clr_of;
	logic clr_ue;
	logic clr_av;
	logic clr_mv;
	logic clr_v;
	logic capture;
	logic overflow;
	logic mask_we;
	logic [2:0] ack_bits;
	logic [2:0] events;
	logic [2:0] irq_status;
	logic [2:0] irq_mask;
	logic [31:0] rd_word;

	ier_bus_slave u_slave (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.avs_read(avs_read),
		.avs_write(avs_write),
		.avs_waitrequest(avs_waitrequest),
		.load(load),
		.commit(commit)
	);

	ier_irq u_irq (
		.ref_clk(ref_clk),
		.nrst(nrst),
		.event_in(events),
		.ack_bits(ack_bits),
		.mask_we(mask_we),
		.mask_in(avs_writedata[2:0]),
		.status(irq_status),
		.mask(irq_mask),
		.irq(irq)
	);

	// write-1-clear decode; each dependency uses the clear of the same write
	always_comb begin
		// non-secure writes are dropped silently, the bus still completes
		wr = commit & avs_write & avs_secure;
		st_wr = wr & ier_pkg::ier_hit(avs_address, ier_pkg::OFS_STATUS) & avs_byteenable[3];
		clr_of = st_wr & avs_writedata[ier_pkg::BIT_OF];
		clr_ue = st_wr & avs_writedata[ier_pkg::BIT_UE] & (!s.of | clr_of);
		clr_av = st_wr & avs_writedata[ier_pkg::BIT_AV] & (!s.ue | clr_ue);
		clr_mv = st_wr & avs_writedata[ier_pkg::BIT_MV] & (!s.ue | clr_ue);
		clr_v = st_wr & avs_writedata[ier_pkg::BIT_V] & (!s.ue | clr_ue) & (!s.av | clr_av)
			& (!s.of | clr_of) & (!s.mv | clr_mv);
		capture = err_valid & !s.v;
		overflow = err_valid & s.v;
		mask_we = wr & ier_pkg::ier_hit(avs_address, ier_pkg::OFS_IRQ_MASK) & avs_byteenable[0];
	end

	// interrupt events; the uncorrected event needs its enable
	always_comb begin
		events = 3'h0;
		events[ier_pkg::IRQ_LOGGED] = capture;
		events[ier_pkg::IRQ_OVERFLOW] = overflow;
		events[ier_pkg::IRQ_UNCORR] = capture & err_uncorrected & s.ui;
		// only bits that the read actually returned are cleared
		ack_bits = 3'h0;
		if (commit & avs_read & avs_secure
			& ier_pkg::ier_hit(avs_address, ier_pkg::OFS_IRQ_STATUS)) begin
			ack_bits = s.rdata[2:0];
		end
	end

	// read mux, sampled in the first cycle of the access
	always_comb begin
		rd_word = ier_pkg::READ_UNMAPPED;
		if (avs_read & avs_secure) begin
			if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_STATUS)) begin
				rd_word[ier_pkg::BIT_AV] = s.av;
				rd_word[ier_pkg::BIT_V] = s.v;
				rd_word[ier_pkg::BIT_UE] = s.ue;
				rd_word[ier_pkg::BIT_OF] = s.of;
				rd_word[ier_pkg::BIT_MV] = s.mv;
				rd_word[ier_pkg::CLASS_LSB +: ier_pkg::CLASS_W] = s.serr;
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ADDR_LOW)) begin
				rd_word = s.addr[31:0];
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ADDR_HIGH)) begin
				rd_word = s.addr[63:32];
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_SOURCE_IDS)) begin
				rd_word[ier_pkg::TXN_LSB +: ier_pkg::TXN_W] = s.txn;
				rd_word[ier_pkg::NODE_LSB +: ier_pkg::NODE_W] = s.node;
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ERR_CTRL)) begin
				rd_word[ier_pkg::BIT_UI] = s.ui;
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_IRQ_STATUS)) begin
				rd_word[ier_pkg::IRQ_W-1:0] = irq_status;
			end else if (ier_pkg::ier_hit(avs_address, ier_pkg::OFS_IRQ_MASK)) begin
				rd_word[ier_pkg::IRQ_W-1:0] = irq_mask;
			end
		end
	end

	// record update; hardware sets win over software clears
	always_comb begin
		next_s = s;
		if (load) begin
			next_s.rdata = rd_word;
		end
		next_s.of = (s.of & !clr_of) | overflow;
		next_s.ue = (s.ue & !clr_ue) | (capture & err_uncorrected);
		next_s.av = (s.av & !clr_av) | capture;
		next_s.mv = (s.mv & !clr_mv) | capture;
		// a fault meeting the clear keeps the record, so overflow never sits on an empty one
		next_s.v = (s.v & !clr_v) | err_valid;
		if (capture) begin
			next_s.serr = err_class;
			next_s.addr = err_addr;
			next_s.txn = err_txn_id;
			next_s.node = err_node_id;
		end else if (clr_v & !overflow) begin
			// an emptied record reports no error
			next_s.serr = ier_pkg::CLASS_NONE;
		end
		if (wr & ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ERR_CTRL) & avs_byteenable[0]) begin
			next_s.ui = avs_writedata[ier_pkg::BIT_UI];
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!nrst) begin
			s <= ier_pkg::RST_STATE;
		end else begin
			s <= next_s;
		end
	end

	// uncorrected is only set together with valid, and the valid clear is gated on
	// uncorrected being clear, so uncorrected never reads set on an empty record
	assign avs_readdata = s.rdata;

	default clocking cb @(posedge ref_clk);
	endclocking

	default disable iff (!nrst);

	logic status_wr;
	assign status_wr = commit && avs_write && avs_secure && avs_byteenable[3]
		&& ier_pkg::ier_hit(avs_address, ier_pkg::OFS_STATUS);

	// secure read in its answer cycle; readdata then holds what the first cycle saw
	logic sec_rd;
	assign sec_rd = commit && avs_read && avs_secure;

	sequence s_first_error;
		err_valid && !s.v;
	endsequence

	sequence s_record_loaded;
		s.v && s.av && s.mv && s.serr == $past(err_class) && s.addr == $past(err_addr)
			&& s.txn == $past(err_txn_id) && s.node == $past(err_node_id);
	endsequence

	a_av_clear_blocked: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_AV] && s.ue
		&& !avs_writedata[ier_pkg::BIT_UE] |=> s.av)
		else $error("address valid cleared while uncorrected held");

	a_v_clear_blocked: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_V] && s.of
		&& !avs_writedata[ier_pkg::BIT_OF] |=> s.v)
		else $error("record valid cleared while overflow held");

	a_ue_clear_blocked: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_UE] && s.of && s.ue
		&& !avs_writedata[ier_pkg::BIT_OF] |=> s.ue)
		else $error("uncorrected cleared while overflow held");

	a_mv_clear_blocked: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_MV] && s.ue
		&& !avs_writedata[ier_pkg::BIT_UE] |=> s.mv)
		else $error("misc valid cleared while uncorrected held");

	a_first_capture: assert property (
		s_first_error |=> s_record_loaded)
		else $error("first error not fully captured");

	a_second_overflow: assert property (
		err_valid && s.v |=> s.of && s.v && $stable(s.serr) && $stable(s.addr))
		else $error("second error overwrote record or missed overflow");

	a_ue_capture: assert property (
		s_first_error |=> s.ue == $past(err_uncorrected))
		else $error("uncorrected flag does not follow the logged error");

	a_av_needs_v: assert property (
		s.av |-> s.v)
		else $error("address valid set without a valid record");

	a_class_cleared: assert property (
		$fell(s.v) |-> s.serr == ier_pkg::CLASS_NONE)
		else $error("class code left behind after record cleared");

	a_nonsecure_write: assert property (
		commit && avs_write && !avs_secure && !err_valid |=>
		$stable(s.v) && $stable(s.av) && $stable(s.ue) && $stable(s.of) && $stable(s.mv))
		else $error("non-secure write changed the record");

	a_addr_low_read: assert property (
		commit && avs_read && avs_secure && ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ADDR_LOW)
		|-> avs_readdata == $past(s.addr[31:0]))
		else $error("low fault address read back wrong");

	a_ids_read: assert property (
		commit && avs_read && avs_secure && ier_pkg::ier_hit(avs_address, ier_pkg::OFS_SOURCE_IDS)
		|-> avs_readdata == {$past(s.txn), $past(s.node)})
		else $error("source id log read back wrong");

	a_uncorr_irq_gate: assert property (
		err_valid && !s.v && err_uncorrected && !s.ui && !irq_status[ier_pkg::IRQ_UNCORR]
		|=> !irq_status[ier_pkg::IRQ_UNCORR])
		else $error("uncorrected interrupt raised while disabled");

	a_of_write_clear: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_OF] && !err_valid |=> !s.of)
		else $error("overflow not cleared by its write");

	a_ue_write_clear: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_UE] && avs_writedata[ier_pkg::BIT_OF]
		&& !err_valid |=> !s.ue)
		else $error("uncorrected not cleared together with overflow");

	a_av_write_clear: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_AV] && avs_writedata[ier_pkg::BIT_UE]
		&& avs_writedata[ier_pkg::BIT_OF] && !err_valid |=> !s.av)
		else $error("address valid not cleared together with uncorrected");

	a_mv_write_clear: assert property (
		status_wr && avs_writedata[ier_pkg::BIT_MV] && avs_writedata[ier_pkg::BIT_UE]
		&& avs_writedata[ier_pkg::BIT_OF] && !err_valid |=> !s.mv)
		else $error("misc valid not cleared together with uncorrected");

	sequence s_clear_all;
		status_wr && avs_writedata[ier_pkg::BIT_AV] && avs_writedata[ier_pkg::BIT_V]
			&& avs_writedata[ier_pkg::BIT_UE] && avs_writedata[ier_pkg::BIT_OF]
			&& avs_writedata[ier_pkg::BIT_MV] && !err_valid;
	endsequence

	sequence s_record_empty;
		!s.v && !s.av && !s.ue && !s.of && !s.mv && s.serr == ier_pkg::CLASS_NONE;
	endsequence

	a_clear_all: assert property (
		s_clear_all |=> s_record_empty)
		else $error("write of every clear bit left the record set");

	a_v_holds: assert property (
		s.v && !status_wr |=> s.v)
		else $error("record valid dropped without a clear");

	a_of_needs_v: assert property (
		s.of |-> s.v)
		else $error("overflow set without a valid record");

	a_ue_needs_v: assert property (
		s.ue |-> s.v)
		else $error("uncorrected set without a valid record");

	a_mv_needs_v: assert property (
		s.mv |-> s.v)
		else $error("misc valid set without a valid record");

	a_class_empty: assert property (
		!s.v |-> s.serr == ier_pkg::CLASS_NONE)
		else $error("class code reported for an empty record");

	a_class_hold: assert property (
		s.v && !status_wr |=> $stable(s.serr))
		else $error("class code changed while the record was held");

	a_fields_hold: assert property (
		s.v |=> $stable(s.addr) && $stable(s.txn) && $stable(s.node))
		else $error("held record fields changed while valid");

	a_ctrl_write: assert property (
		commit && avs_write && avs_secure && avs_byteenable[0]
		&& ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ERR_CTRL)
		|=> s.ui == $past(avs_writedata[ier_pkg::BIT_UI]))
		else $error("uncorrected interrupt enable not written");

	a_nonsecure_ctrl: assert property (
		commit && avs_write && !avs_secure |=> $stable(s.ui))
		else $error("non-secure write changed the interrupt enable");

	a_nonsecure_read: assert property (
		commit && avs_read && !avs_secure |-> avs_readdata == ier_pkg::READ_UNMAPPED)
		else $error("non-secure read returned data");

	a_addr_high_read: assert property (
		sec_rd && ier_pkg::ier_hit(avs_address, ier_pkg::OFS_ADDR_HIGH)
		|-> avs_readdata == $past(s.addr[63:32]))
		else $error("high fault address read back wrong");

	a_status_read: assert property (
		sec_rd && ier_pkg::ier_hit(avs_address, ier_pkg::OFS_STATUS)
		|-> avs_readdata[ier_pkg::BIT_AV] == $past(s.av)
		&& avs_readdata[ier_pkg::BIT_V] == $past(s.v)
		&& avs_readdata[ier_pkg::BIT_UE] == $past(s.ue)
		&& avs_readdata[ier_pkg::BIT_OF] == $past(s.of)
		&& avs_readdata[ier_pkg::BIT_MV] == $past(s.mv))
		else $error("status flags read back wrong");

	a_class_read: assert property (
		sec_rd && ier_pkg::ier_hit(avs_address, ier_pkg::OFS_STATUS)
		|-> avs_readdata[ier_pkg::CLASS_LSB +: ier_pkg::CLASS_W] == $past(s.serr))
		else $error("class code read back wrong");

	a_logged_irq: assert property (
		s_first_error |=> irq_status[ier_pkg::IRQ_LOGGED])
		else $error("logged interrupt bit not set on capture");

	a_overflow_irq: assert property (
		err_valid && s.v |=> irq_status[ier_pkg::IRQ_OVERFLOW])
		else $error("overflow interrupt bit not set");

	a_uncorr_irq_on: assert property (
		err_valid && !s.v && err_uncorrected && s.ui |=> irq_status[ier_pkg::IRQ_UNCORR])
		else $error("enabled uncorrected interrupt not raised");

	a_readdata_hold: assert property (
		!load |=> $stable(avs_readdata))
		else $error("read data changed outside a load cycle");

	a_mask_write: assert property (
		commit && avs_write && avs_secure && avs_byteenable[0]
		&& ier_pkg::ier_hit(avs_address, ier_pkg::OFS_IRQ_MASK) |=> irq_mask == $past(avs_writedata[2:0]))
		else $error("interrupt mask not written");
endmodule
`default_nettype wire

// ==== verification/tb.sv ====
`timescale 1ns/1ps
`default_nettype none
module tb;
	logic ref_clk = 1'h0;
	logic nrst = 1'h0;
	logic [7:0] avs_address = 8'h00;
	logic avs_read = 1'h0;
	logic avs_write = 1'h0;
	logic [31:0] avs_writedata = 32'h0;
	logic [3:0] avs_byteenable = 4'hf;
	logic avs_secure = 1'h1;
	logic [31:0] avs_readdata;
	logic avs_waitrequest;
	logic err_valid = 1'h0;
	logic [7:0] err_class = 8'h00;
	logic err_uncorrected = 1'h0;
	logic [63:0] err_addr = 64'h0;
	logic [23:0] err_txn_id = 24'h0;
	logic [7:0] err_node_id = 8'h00;
	logic irq;
	int n_mismatch = 0;
	int tests_run = 0;
	logic [31:0] clr_all;
	logic [31:0] q;

	ier_main u_ier_main (
		.ref_clk(ref_clk), .nrst(nrst), .avs_address(avs_address), .avs_read(avs_read),
		.avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
		.avs_secure(avs_secure), .avs_readdata(avs_readdata),
		.avs_waitrequest(avs_waitrequest), .err_valid(err_valid), .err_class(err_class),
		.err_uncorrected(err_uncorrected), .err_addr(err_addr), .err_txn_id(err_txn_id),
		.err_node_id(err_node_id), .irq(irq)
	);

	always #12.5 ref_clk = ~ref_clk;

	task automatic stop_test();
		$display("checks %0d mismatches %0d", tests_run, n_mismatch);
		if (n_mismatch == 0 && tests_run > 0) begin
			$display("SIMULATION PASSED");
		end else begin
			$display("SIMULATION FAILED");
		end
		$finish;
	endtask

	task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
		tests_run++;
		if (seen !== exp) begin
			$display("unexpected %s expected %h seen %h", name, exp, seen);
			n_mismatch++;
		end
	endtask

	function automatic logic [31:0] st(input logic av, input logic v, input logic ue,
		input logic of, input logic mv, input logic [7:0] c);
		logic [31:0] w;
		w = {24'h0, c};
		w[ier_pkg::BIT_AV] = av;
		w[ier_pkg::BIT_V] = v;
		w[ier_pkg::BIT_UE] = ue;
		w[ier_pkg::BIT_OF] = of;
		w[ier_pkg::BIT_MV] = mv;
		return w;
	endfunction

	// request held until the edge that samples waitrequest low; data taken there
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic sec, input logic [3:0] be, output logic [31:0] rq);
		int i;
		@(posedge ref_clk);
		avs_address <= a;
		avs_writedata <= d;
		avs_secure <= sec;
		avs_byteenable <= be;
		avs_read <= ~w;
		avs_write <= w;
		for (i = 0; i < 20; i++) begin
			@(posedge ref_clk);
			if (avs_waitrequest === 1'h0) break;
		end
		rq = avs_readdata;
		avs_read <= 1'h0;
		avs_write <= 1'h0;
		if (i == 20) begin
			n_mismatch++;
			stop_test();
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] x;
		bus(1'h1, a, d, 1'h1, 4'hf, x);
	endtask

	task automatic rdc(input string n, input logic [7:0] a, input logic [31:0] e);
		logic [31:0] x;
		bus(1'h0, a, 32'h0, 1'h1, 4'hf, x);
		chk(n, x, e);
	endtask

	// n back-to-back faults; each later one carries an inverted address
	task automatic flt(input logic [7:0] c, input logic u, input logic [63:0] a,
		input logic [23:0] t, input logic [7:0] nd, input int n);
		for (int i = 0; i < n; i++) begin
			@(posedge ref_clk);
			err_valid <= 1'h1;
			err_class <= c;
			err_uncorrected <= u;
			err_addr <= (i == 0) ? a : ~a;
			err_txn_id <= t;
			err_node_id <= nd;
		end
		@(posedge ref_clk);
		err_valid <= 1'h0;
	endtask

	task automatic t_reset();
		rdc("status", ier_pkg::OFS_STATUS, 32'h0);
		rdc("addr_low", ier_pkg::OFS_ADDR_LOW, 32'h0);
		rdc("ids", ier_pkg::OFS_SOURCE_IDS, 32'h0);
		rdc("unmapped", 8'h1c, ier_pkg::READ_UNMAPPED);
		chk("irq", {31'h0, irq}, 32'h0);
	endtask

	task automatic t_capture();
		logic [7:0] codes [3];
		logic [63:0] a;
		logic [23:0] t;
		logic [7:0] nd;
		codes = '{ier_pkg::CLASS_DECODE, ier_pkg::CLASS_SLAVE_RESP, ier_pkg::CLASS_TIMEOUT};
		foreach (codes[i]) begin
			a = {32'h8000_0f10 + 32'(i), 32'h1234_5678 + 32'(i)};
			t = 24'ha55a0f + 24'(i);
			nd = 8'h3c + 8'(i);
			flt(codes[i], 1'h0, a, t, nd, 1);
			rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 0, 0, 1, codes[i]));
			rdc("addr_low", ier_pkg::OFS_ADDR_LOW, a[31:0]);
			rdc("addr_high", ier_pkg::OFS_ADDR_HIGH, a[63:32]);
			rdc("ids", ier_pkg::OFS_SOURCE_IDS, {t, nd});
			chk("irq", {31'h0, irq}, 32'h0);
			wr(ier_pkg::OFS_STATUS, clr_all);
			rdc("status", ier_pkg::OFS_STATUS, 32'h0);
		end
	endtask

	// each flag clear is tried while its blocker is still set
	task automatic t_overflow();
		logic [7:0] c;
		c = ier_pkg::CLASS_SLAVE_RESP;
		flt(c, 1'h1, 64'h0bad_cafe_0000_1000, 24'h00_0777, 8'h05, 2);
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 1, 1, 1, c));
		rdc("addr_low", ier_pkg::OFS_ADDR_LOW, 32'h0000_1000);
		rdc("irq_status", ier_pkg::OFS_IRQ_STATUS, 32'h3);
		wr(ier_pkg::OFS_STATUS, st(0, 0, 1, 0, 0, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 1, 1, 1, c));
		wr(ier_pkg::OFS_STATUS, st(0, 1, 0, 0, 0, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 1, 1, 1, c));
		wr(ier_pkg::OFS_STATUS, st(0, 0, 0, 1, 0, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 1, 0, 1, c));
		wr(ier_pkg::OFS_STATUS, st(1, 0, 0, 0, 1, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 1, 0, 1, c));
		wr(ier_pkg::OFS_STATUS, st(1, 0, 1, 0, 1, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, st(0, 1, 0, 0, 0, c));
		wr(ier_pkg::OFS_STATUS, st(0, 1, 0, 0, 0, 8'h00));
		rdc("status", ier_pkg::OFS_STATUS, 32'h0);
	endtask

	task automatic t_secure();
		logic [7:0] c;
		c = ier_pkg::CLASS_TIMEOUT;
		flt(c, 1'h0, 64'h0000_0001_0000_00f0, 24'h12_3456, 8'h7e, 1);
		bus(1'h0, ier_pkg::OFS_STATUS, 32'h0, 1'h0, 4'hf, q);
		chk("ns_status", q, 32'h0);
		bus(1'h0, ier_pkg::OFS_ADDR_LOW, 32'h0, 1'h0, 4'hf, q);
		chk("ns_addr_low", q, 32'h0);
		bus(1'h1, ier_pkg::OFS_STATUS, clr_all, 1'h0, 4'hf, q);
		// without the top byte enable the flag byte is not written
		bus(1'h1, ier_pkg::OFS_STATUS, clr_all, 1'h1, 4'h7, q);
		rdc("status", ier_pkg::OFS_STATUS, st(1, 1, 0, 0, 1, c));
		wr(ier_pkg::OFS_STATUS, clr_all);
		rdc("status", ier_pkg::OFS_STATUS, 32'h0);
	endtask

	task automatic t_irq();
		wr(ier_pkg::OFS_ERR_CTRL, 32'h4);
		rdc("ctrl", ier_pkg::OFS_ERR_CTRL, 32'h4);
		wr(ier_pkg::OFS_IRQ_MASK, 32'h7);
		bus(1'h0, ier_pkg::OFS_IRQ_STATUS, 32'h0, 1'h1, 4'hf, q);
		flt(ier_pkg::CLASS_DECODE, 1'h1, 64'h40, 24'h1, 8'h1, 1);
		repeat (2) @(posedge ref_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		rdc("irq_status", ier_pkg::OFS_IRQ_STATUS, 32'h5);
		repeat (2) @(posedge ref_clk);
		chk("irq", {31'h0, irq}, 32'h0);
		rdc("irq_status", ier_pkg::OFS_IRQ_STATUS, 32'h0);
		wr(ier_pkg::OFS_STATUS, clr_all);
		wr(ier_pkg::OFS_ERR_CTRL, 32'h0);
		wr(ier_pkg::OFS_IRQ_MASK, 32'h0);
		flt(ier_pkg::CLASS_DECODE, 1'h1, 64'h80, 24'h2, 8'h2, 1);
		repeat (2) @(posedge ref_clk);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(ier_pkg::OFS_IRQ_MASK, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq", {31'h0, irq}, 32'h1);
		rdc("irq_status", ier_pkg::OFS_IRQ_STATUS, 32'h1);
		repeat (2) @(posedge ref_clk);
		chk("irq", {31'h0, irq}, 32'h0);
		wr(ier_pkg::OFS_STATUS, clr_all);
	endtask

	initial begin
		clr_all = st(1, 1, 1, 1, 1, 8'h00);
		repeat (2) @(posedge ref_clk);
		nrst <= 1'h1;
		t_reset();
		t_capture();
		t_overflow();
		t_secure();
		t_irq();
		stop_test();
	end
endmodule
`default_nettype wire
